// >>> src/wdhw_ctrl.sv
/*
  watchdog, interrupt latch, halt and wake-up controller.
  assumes a cpu core on sys_clk giving one-cycle strobes for its
  instructions, pins and slow clocks arriving unsynchronised.
*/
`timescale 1ns/100ps
`default_nettype none
module wdhw_ctrl (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  // configuration options
  input  wire logic       optWdogEnable,
  input  wire logic [1:0] optWdogSrc,
  input  wire logic       optDualClear,
  input  wire logic       optRcOsc,
  input  wire logic [7:0] optWakeMask,
  // cpu strobes
  input  wire logic       phaseTwoPulse,
  input  wire logic       stackFull,
  input  wire logic       clearWdogOp,
  input  wire logic       clearWdogFirst,
  input  wire logic       clearWdogSecond,
  input  wire logic       haltOp,
  input  wire logic       retiOp,
  input  wire logic       timerOverflow,
  // pins and slow clocks
  input  wire logic       extRstPin_n,
  input  wire logic       extIntPin_n,
  input  wire logic [7:0] portAPins,
  input  wire logic       wdogOscClk,
  input  wire logic       rtcClk,
  // results
  output logic            irqTake,
  output logic      [7:0] irqVector,
  output logic            chipReset,
  output logic            warmReset,
  output logic            cpuHold,
  output logic            resumeGo,
  output logic            sysOscEnable,
  output logic            clkDivOutPin,
  output logic            sleepFlag,
  output logic            expiryFlag
);
  //////////////////////////////////////////////////////////////////
  function automatic logic [14:0] wdLimit(input logic [2:0] scale);
    wdLimit = 15'((32'd256 << scale) - 32'd1);
  endfunction

  //////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [11:0] syncA_reg;
  logic [11:0] syncB_reg;
  logic [11:0] syncC_reg;

  always_ff @(posedge sys_clk) begin
    syncA_reg <= {rtcClk, wdogOscClk, portAPins, extIntPin_n, extRstPin_n};
    syncB_reg <= syncA_reg;
    syncC_reg <= syncB_reg;
  end

  logic       pinRst;
  logic       intFall;
  logic [7:0] portFall;
  logic       oscRise;
  logic       rtcRise;

  assign pinRst   = ~syncB_reg[0];
  assign intFall  = syncC_reg[1] & ~syncB_reg[1];
  assign portFall = syncC_reg[9:2] & ~syncB_reg[9:2];
  assign oscRise  = syncB_reg[10] & ~syncC_reg[10];
  assign rtcRise  = syncB_reg[11] & ~syncC_reg[11];

  //////////////////////////////////////////////////////////////////
  // state
  wdhw_pkg::wdhw_state_e state_reg;
  wdhw_pkg::wdhw_state_e state_next;
  logic [7:0]  intCtrl_reg;
  logic [7:0]  wdogSet_reg;
  logic [14:0] wdCnt_reg;
  logic [1:0]  instrDiv_reg;
  logic [10:0] sstCnt_reg;
  logic [1:0]  wakeBlock_reg;
  logic        firstSeen_reg;
  logic        secondSeen_reg;

  logic asleep;
  logic instrTick;
  logic wdTick;
  logic wdOverflow;
  logic wdClear;
  logic clearDone;
  logic serveOk;
  logic servePin;
  logic wdHalt;
  logic intWake;
  logic portWake;
  logic anyWake;

  assign asleep = (state_reg == wdhw_pkg::ST_SLEEP);
  assign wdHalt = haltOp & (state_reg == wdhw_pkg::ST_RUN);

  //////////////////////////////////////////////////////////////////
  // instruction clock and divided clock output
  // divider held at zero in power-down
  always_ff @(posedge sys_clk) begin
    if (!rst_n || asleep) begin
      instrDiv_reg <= 2'h0;
    end else begin
      instrDiv_reg <= instrDiv_reg + 2'h1;
    end
  end
  assign instrTick = (instrDiv_reg == 2'(wdhw_pkg::INSTR_DIV - 1));

  // system clock divided by four when rc option chosen
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clkDivOutPin <= 1'b0;
    end else begin
      clkDivOutPin <= optRcOsc & ~asleep & instrDiv_reg[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sysOscEnable <= 1'b1;
    end else begin
      sysOscEnable <= (state_next != wdhw_pkg::ST_SLEEP);
    end
  end

  //////////////////////////////////////////////////////////////////
  // watchdog clock choice
  always_comb begin
    unique case (optWdogSrc)
      wdhw_pkg::SRC_WDOG_OSC: wdTick = oscRise;
      wdhw_pkg::SRC_RTC:      wdTick = rtcRise;
      wdhw_pkg::SRC_INSTR:    wdTick = instrTick & ~asleep;
      default:                wdTick = 1'b0;
    endcase
  end

  // dual clear scheme needs both ops
  always_ff @(posedge sys_clk) begin
    if (!rst_n || pinRst || clearDone || wdOverflow) begin
      firstSeen_reg  <= 1'b0;
      secondSeen_reg <= 1'b0;
    end else begin
      firstSeen_reg  <= firstSeen_reg | clearWdogFirst;
      secondSeen_reg <= secondSeen_reg | clearWdogSecond;
    end
  end

  // clear ops ignored when the watchdog is disabled
  assign clearDone = optWdogEnable & (optDualClear
                   ? ((firstSeen_reg | clearWdogFirst) & (secondSeen_reg | clearWdogSecond))
                   : clearWdogOp);

  // pin reset, clear op or halt clears the 15-bit counter; instrDiv_reg is not cleared
  assign wdClear = pinRst | clearDone | wdHalt;

  assign wdOverflow = optWdogEnable & wdTick & ~pinRst
                    & (wdCnt_reg == wdLimit(wdogSet_reg[2:0]));

  // counter restarts from zero after halt entry
  always_ff @(posedge sys_clk) begin
    if (!rst_n || wdClear || wdOverflow || !optWdogEnable) begin
      wdCnt_reg <= 15'h0000;
    end else if (wdTick && state_reg != wdhw_pkg::ST_SETTLE) begin
      wdCnt_reg <= wdCnt_reg + 15'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////
  // halt, wake and start-up delay
  assign portWake = |(portFall & optWakeMask);
  // flags pending at halt entry cannot wake
  assign intWake = (intFall & ~wakeBlock_reg[0])
                 | (timerOverflow & ~wakeBlock_reg[1]);
  assign anyWake = pinRst | intWake | portWake | wdOverflow;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      wdhw_pkg::ST_RUN: begin
        if (wdOverflow) begin
          state_next = wdhw_pkg::ST_SETTLE;
        end else if (haltOp) begin
          state_next = wdhw_pkg::ST_SLEEP;
        end
      end
      wdhw_pkg::ST_SLEEP: begin
        if (anyWake) begin
          state_next = wdhw_pkg::ST_SETTLE;
        end
      end
      wdhw_pkg::ST_SETTLE: begin
        if (sstCnt_reg == wdhw_pkg::SST_LAST) begin
          state_next = wdhw_pkg::ST_RUN;
        end
      end
      default: state_next = wdhw_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= wdhw_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // dummy delay of 1024 system clock periods
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state_reg != wdhw_pkg::ST_SETTLE) begin
      sstCnt_reg <= 11'h000;
    end else begin
      sstCnt_reg <= sstCnt_reg + 11'h001;
    end
  end

  // resume strobe; the core continues at the next instruction
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cpuHold  <= 1'b0;
      resumeGo <= 1'b0;
    end else begin
      cpuHold  <= (state_next != wdhw_pkg::ST_RUN);
      resumeGo <= (state_reg == wdhw_pkg::ST_SETTLE)
                & (state_next == wdhw_pkg::ST_RUN);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wakeBlock_reg <= 2'h0;
    end else if (wdHalt) begin
      wakeBlock_reg <= {intCtrl_reg[wdhw_pkg::TREQ_BIT],
                        intCtrl_reg[wdhw_pkg::EREQ_BIT]};
    end
  end

  // chip reset on pin reset or on overflow when not asleep, warm reset on overflow when asleep
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chipReset <= 1'b0;
      warmReset <= 1'b0;
    end else begin
      chipReset <= (wdOverflow & ~asleep) | pinRst;
      warmReset <= wdOverflow & asleep;
    end
  end

  //////////////////////////////////////////////////////////////////
  // status flags
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sleepFlag  <= 1'b0;
      expiryFlag <= 1'b0;
    end else if (wdOverflow) begin
      // expiry on overflow; sleep flag kept
      expiryFlag <= 1'b1;
    end else if (wdHalt) begin
      // halt sets sleep and clears expiry
      sleepFlag  <= 1'b1;
      expiryFlag <= 1'b0;
    end else if (clearDone) begin
      sleepFlag  <= 1'b0;
      expiryFlag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////
  // interrupt latch and arbitration
  // decided only on the phase-two pulse
  assign serveOk = phaseTwoPulse & (state_reg == wdhw_pkg::ST_RUN) & ~stackFull
                 & intCtrl_reg[wdhw_pkg::GIE_BIT]
                 & ((intCtrl_reg[wdhw_pkg::PIE_BIT] & intCtrl_reg[wdhw_pkg::EREQ_BIT])
                  | (intCtrl_reg[wdhw_pkg::TIE_BIT] & intCtrl_reg[wdhw_pkg::TREQ_BIT]));
  assign servePin = intCtrl_reg[wdhw_pkg::PIE_BIT] & intCtrl_reg[wdhw_pkg::EREQ_BIT];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irqTake   <= 1'b0;
      irqVector <= 8'h00;
    end else begin
      irqTake <= serveOk;
      if (serveOk) begin
        irqVector <= servePin ? wdhw_pkg::PIN_VECTOR : wdhw_pkg::TIMER_VECTOR;
      end
    end
  end

  logic       ctrlWr;
  logic [7:0] ctrlBase;

  assign ctrlWr = regWrEn & (regAddr == wdhw_pkg::IRQ_CTRL_ADDR);

  always_comb begin
    ctrlBase = ctrlWr ? regWrData : intCtrl_reg;
    if (serveOk) begin
      ctrlBase[wdhw_pkg::GIE_BIT] = 1'b0;
      if (servePin) begin
        ctrlBase[wdhw_pkg::EREQ_BIT] = 1'b0;
      end else begin
        ctrlBase[wdhw_pkg::TREQ_BIT] = 1'b0;
      end
    end
    if (retiOp) begin
      ctrlBase[wdhw_pkg::GIE_BIT] = 1'b1;
    end
    // flags held; a new request wins over a write or service clear, not over chip reset
    ctrlBase[wdhw_pkg::EREQ_BIT] = ctrlBase[wdhw_pkg::EREQ_BIT] | intFall;
    ctrlBase[wdhw_pkg::TREQ_BIT] = ctrlBase[wdhw_pkg::TREQ_BIT] | timerOverflow;
    ctrlBase[3] = 1'b0;
    ctrlBase[7:6] = 2'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || chipReset) begin
      intCtrl_reg <= wdhw_pkg::IRQ_CTRL_RST;
    end else begin
      intCtrl_reg <= ctrlBase;
    end
  end

  //////////////////////////////////////////////////////////////////
  // watchdog setting register
  // upper bits are plain storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n || chipReset) begin
      wdogSet_reg <= wdhw_pkg::WDOG_SET_RST;
    end else if (regWrEn && regAddr == wdhw_pkg::WDOG_SET_ADDR) begin
      wdogSet_reg <= regWrData;
    end
  end

  //////////////////////////////////////////////////////////////////
  // read port
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !regRdEn) begin
      regRdData <= 8'h00;
    end else begin
      unique case (regAddr)
        wdhw_pkg::IRQ_CTRL_ADDR: regRdData <= intCtrl_reg;
        wdhw_pkg::WDOG_SET_ADDR: regRdData <= wdogSet_reg;
        wdhw_pkg::STATUS_ADDR: begin
          regRdData <= 8'h00;
          regRdData[wdhw_pkg::SLEEP_BIT]  <= sleepFlag;
          regRdData[wdhw_pkg::EXPIRY_BIT] <= expiryFlag;
        end
        default: regRdData <= 8'h00;
      endcase
    end
  end
endmodule // wdhw_ctrl
`default_nettype wire

// >>> src/wdhw_pkg.sv
/*
  constants for the watchdog, halt and wake-up controller.
  assumes an 8-bit register port and one system clock.
*/
`default_nettype none
package wdhw_pkg;
  // register addresses
  localparam logic [7:0] WDOG_SET_ADDR = 8'h09;
  localparam logic [7:0] STATUS_ADDR   = 8'h0a;
  localparam logic [7:0] IRQ_CTRL_ADDR = 8'h0b;
  // irq_control fields
  localparam int GIE_BIT  = 0;
  localparam int PIE_BIT  = 1;
  localparam int TIE_BIT  = 2;
  localparam int EREQ_BIT = 4;
  localparam int TREQ_BIT = 5;
  // status fields
  localparam int SLEEP_BIT  = 4;
  localparam int EXPIRY_BIT = 5;
  // reset values
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] WDOG_SET_RST = 8'h07;
  // vectors
  localparam logic [7:0] PIN_VECTOR   = 8'h04;
  localparam logic [7:0] TIMER_VECTOR = 8'h08;
  // watchdog clock sources
  localparam logic [1:0] SRC_WDOG_OSC = 2'h0;
  localparam logic [1:0] SRC_RTC      = 2'h1;
  localparam logic [1:0] SRC_INSTR    = 2'h2;
  // divider widths
  localparam int BASE_BITS  = 8;
  localparam int SCALE_BITS = 7;
  localparam int CNT_BITS   = BASE_BITS + SCALE_BITS;
  localparam int INSTR_DIV  = 4;
  // start-up delay after wake-up, in system clock periods
  localparam int         SST_CYCLES = 1024;
  localparam logic [10:0] SST_LAST  = 11'(SST_CYCLES - 1);
  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_SLEEP  = 2'b01,
    ST_SETTLE = 2'b10
  } wdhw_state_e;
endpackage
`default_nettype wire

// >>> tb/wdhw_ctrl_chk.sv
/*
  port assertions for the watchdog, halt and wake-up controller.
  assumes one sys_clk domain and a synchronous active-low rst_n.
*/
`timescale 1ns/100ps
`default_nettype none
module wdhw_ctrl_chk (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // inputs watched
  input wire logic       regRdEn,
  input wire logic       phaseTwoPulse,
  input wire logic       stackFull,
  input wire logic       haltOp,
  input wire logic       optRcOsc,
  input wire logic       optWdogEnable,
  // outputs watched
  input wire logic [7:0] regRdData,
  input wire logic       irqTake,
  input wire logic [7:0] irqVector,
  input wire logic       chipReset,
  input wire logic       warmReset,
  input wire logic       cpuHold,
  input wire logic       resumeGo,
  input wire logic       sysOscEnable,
  input wire logic       clkDivOutPin,
  input wire logic       sleepFlag,
  input wire logic       expiryFlag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // cycles spent held with the oscillator running
  logic [10:0] holdCnt_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !cpuHold || !sysOscEnable || chipReset) begin
      holdCnt_reg <= 11'h000;
    end else if (holdCnt_reg != 11'h7ff) begin
      holdCnt_reg <= holdCnt_reg + 11'h001;
    end
  end
  sequence haltEntry;
    haltOp && !cpuHold;
  endsequence
  sequence asleep;
    sleepFlag && !expiryFlag && !sysOscEnable && cpuHold;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data not zero outside read slot");
  AST_TAKE_CAUSE: assert property (irqTake |-> $past(phaseTwoPulse) && !$past(stackFull))
    else $error("service without phase pulse or with full stack");
  AST_TAKE_ONE: assert property (irqTake |=> !irqTake)
    else $error("service pulse longer than one cycle");
  AST_VECTOR: assert property (irqTake |-> irqVector inside {8'h04, 8'h08})
    else $error("bad interrupt vector");
  AST_HALT: assert property (haltEntry |=> asleep)
    else $error("halt entry outputs wrong");
  AST_WARM: assert property (warmReset |-> $past(sleepFlag) && !$past(sysOscEnable))
    else $error("warm reset outside power-down");
  AST_EXPIRY: assert property ($rose(expiryFlag) |-> chipReset || warmReset)
    else $error("expiry flag set without reset");
  AST_DOG_OFF: assert property (!optWdogEnable && !$past(optWdogEnable) |-> !$rose(expiryFlag))
    else $error("disabled watchdog expired");
  AST_OSC_DIV: assert property (optRcOsc && $rose(clkDivOutPin) |=> clkDivOutPin ##1 !clkDivOutPin)
    else $error("divided clock not a four-cycle square");
  AST_SETTLE: assert property (resumeGo |-> holdCnt_reg inside {[11'h3fa:11'h406]})
    else $error("settle delay length wrong");
endmodule // wdhw_ctrl_chk
bind wdhw_ctrl wdhw_ctrl_chk u_chk (.sys_clk, .rst_n, .regRdEn, .phaseTwoPulse, .stackFull,
  .haltOp, .optRcOsc, .optWdogEnable, .regRdData, .irqTake, .irqVector, .chipReset,
  .warmReset, .cpuHold, .resumeGo, .sysOscEnable, .clkDivOutPin, .sleepFlag, .expiryFlag);
`default_nettype wire

// >>> tb/wdhw_ctrl_tb.sv
/*
  self-checking bench for the watchdog, halt and wake-up controller.
  assumes the design alone on a 250 MHz sys_clk with the checker bound.
*/
`timescale 1ns/100ps
`default_nettype none
module wdhw_ctrl_tb;
  localparam logic [7:0] IC = wdhw_pkg::IRQ_CTRL_ADDR;
  localparam logic [7:0] WS = wdhw_pkg::WDOG_SET_ADDR;
  localparam logic [7:0] ST = wdhw_pkg::STATUS_ADDR;
  logic       sys_clk, rst_n, wen, ren, dogEn, dual, rc, stk, eintN, erstN, woc, rtc;
  logic       take, chip, warm, hold, go, osc, dout, slp, expF;
  logic [1:0] src;
  logic [6:0] stb;
  logic [7:0] addr, wd, rdd, pa, mask, vec;
  int         err_count, checked, n, rstCnt, warmCnt;
  ////////////////////////////////////////////////////////////////////////////
  wdhw_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(addr), .regWrData(wd),
    .regWrEn(wen), .regRdEn(ren), .regRdData(rdd), .optWdogEnable(dogEn),
    .optWdogSrc(src), .optDualClear(dual), .optRcOsc(rc), .optWakeMask(mask),
    .phaseTwoPulse(stb[0]), .stackFull(stk), .clearWdogOp(stb[1]),
    .clearWdogFirst(stb[2]), .clearWdogSecond(stb[3]), .haltOp(stb[4]),
    .retiOp(stb[5]), .timerOverflow(stb[6]), .extRstPin_n(erstN), .extIntPin_n(eintN),
    .portAPins(pa), .wdogOscClk(woc), .rtcClk(rtc), .irqTake(take), .irqVector(vec),
    .chipReset(chip), .warmReset(warm), .cpuHold(hold), .resumeGo(go),
    .sysOscEnable(osc), .clkDivOutPin(dout), .sleepFlag(slp), .expiryFlag(expF));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    woc = 1'b0;
    forever #10 woc = ~woc;
  end
  // rtc clock rises every 16 ns, four system clocks
  initial begin
    rtc = 1'b0;
    forever #8 rtc = ~rtc;
  end
  always @(posedge sys_clk) begin
    if (rst_n && chip) rstCnt++;
    if (rst_n && warm) warmCnt++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    checked++;
    if (got !== want) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  function automatic logic [7:0] inr(input int lo, input int hi);
    return 8'(n >= lo && n <= hi);
  endfunction
  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wd <= d;
    wen <= 1'b1;
    @(posedge sys_clk);
    wen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge sys_clk);
    addr <= a;
    ren <= 1'b1;
    @(posedge sys_clk);
    ren <= 1'b0;
    #1 chk(rdd, want);
  endtask
  task automatic pls(input int i);
    @(posedge sys_clk);
    stb[i] <= 1'b1;
    @(posedge sys_clk);
    stb[i] <= 1'b0;
    #1;
  endtask
  // waits for chip reset (0), warm reset (1) or resume (2)
  task automatic wt(input int s, input int lim, input bit must);
    n = 0;
    while (n < lim && !(s == 0 ? chip : s == 1 ? warm : go)) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (must && n >= lim) begin
      err_count++;
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #300us;
    err_count++;
    final_report();
  end
  initial begin
    {rst_n, wen, ren, dogEn, dual, rc, stk} = 7'h00;
    {eintN, erstN, src, stb, addr, wd} = {2'b11, 2'h2, 7'h00, 16'h0000};
    pa = 8'hff;
    mask = 8'h00;
    {err_count, checked, rstCnt, warmCnt} = {4{32'h0}};
    idle(8);
    rst_n <= 1'b1;
    rd(IC, 8'h00);
    rd(WS, 8'h07);
    wr(WS, 8'hf8);
    rd(WS, 8'hf8);
    wr(IC, 8'hcf);
    rd(IC, 8'h07);
    rd(8'h33, 8'h00);
    // timer request, then pin beats timer
    wr(IC, 8'h05);
    pls(6);
    pls(0);
    chk({7'h00, take}, 8'h01);
    chk(vec, 8'h08);
    rd(IC, 8'h04);
    wr(IC, 8'h07);
    @(posedge sys_clk) eintN <= 1'b0;
    pls(6);
    idle(4);
    rd(IC, 8'h37);
    pls(0);
    chk(vec, 8'h04);
    rd(IC, 8'h26);
    pls(5);
    pls(0);
    chk(vec, 8'h08);
    // masked and stack-full requests stay pending
    eintN <= 1'b1;
    wr(IC, 8'h06);
    pls(6);
    pls(0);
    chk({7'h00, take}, 8'h00);
    rd(IC, 8'h26);
    stk <= 1'b1;
    wr(IC, 8'h27);
    pls(0);
    chk({7'h00, take}, 8'h00);
    stk <= 1'b0;
    pls(0);
    chk({7'h00, take}, 8'h01);
    wr(IC, 8'h00);
    // divided clock output
    rc <= 1'b1;
    idle(3);
    n = 0;
    repeat (40) begin
      @(posedge sys_clk);
      #1 n += int'(dout);
    end
    chk(8'(n), 8'h14);
    rc <= 1'b0;
    // run-mode overflow on the instruction clock, scale 0 then 1
    @(posedge sys_clk) dogEn <= 1'b1;
    wt(0, 1200, 1);
    chk(inr(1016, 1032), 8'h01);
    #4 chk({7'h00, expF}, 8'h01);
    wt(2, 1100, 1);
    rd(ST, 8'h20);
    wr(WS, 8'h01);
    pls(1);
    wt(0, 2200, 1);
    chk(inr(2040, 2056), 8'h01);
    wt(2, 1100, 1);
    wr(WS, 8'h00);
    // single, first-only and dual clears
    pls(1);
    rstCnt = 0;
    repeat (3) begin
      idle(700);
      pls(1);
    end
    chk(8'(rstCnt), 8'h00);
    dual <= 1'b1;
    repeat (3) begin
      idle(700);
      pls(2);
    end
    chk(8'(rstCnt != 0), 8'h01);
    wt(2, 1100, 0);
    wr(WS, 8'h00);
    pls(2);
    pls(3);
    rstCnt = 0;
    repeat (3) begin
      idle(650);
      pls(3);
      pls(2);
    end
    chk(8'(rstCnt), 8'h00);
    dogEn <= 1'b0;
    idle(1500);
    chk(8'(rstCnt), 8'h00);
    // halt on the instruction clock, wake by port a
    {dogEn, dual} <= 2'b10;
    pls(1);
    pls(4);
    chk({4'h0, slp, expF, osc, hold}, 8'h09);
    warmCnt = 0;
    idle(1500);
    chk(8'(warmCnt), 8'h00);
    mask <= 8'h04;
    pa <= 8'hfb;
    wt(2, 1100, 1);
    chk(inr(1024, 1034), 8'h01);
    pa <= 8'hff;
    // interrupt wake, then a pending flag cannot wake
    pls(4);
    pls(6);
    wt(2, 1100, 1);
    pls(4);
    pls(6);
    wt(2, 1100, 0);
    chk(8'(n == 1100), 8'h01);
    pa <= 8'hfb;
    wt(2, 1100, 1);
    pa <= 8'hff;
    wr(IC, 8'h00);
    // halt on the own oscillator ends in a warm reset
    src <= 2'h0;
    pls(4);
    wt(1, 1600, 1);
    chk(inr(1276, 1296), 8'h01);
    #4 chk({6'h00, slp, expF}, 8'h03);
    wt(2, 1100, 1);
    // pin reset clears the control register
    wr(IC, 8'h07);
    erstN <= 1'b0;
    idle(4);
    erstN <= 1'b1;
    idle(4);
    rd(IC, 8'h00);
    // run-mode overflow on the rtc clock
    src <= 2'h1;
    wr(WS, 8'h00);
    pls(1);
    wt(0, 1200, 1);
    chk(inr(1016, 1032), 8'h01);
    final_report();
  end
endmodule // wdhw_ctrl_tb
`default_nettype wire
